// ### src/kmpa_adapter.sv
// Keyboard and mouse pin adapter with APB status and wake interrupt.
// Assumes pclk at 100 MHz, presetn asynchronous active low, and
// controller core port latches with one-cycle write strobes.
//
// Overview of operation
// - Keyboard clock pin pulled low while port 2 bit 6 is one.
// - Keyboard clock pin level feeds test input zero.
// - Keyboard data pin pulled low while port 2 bit 7 is one.
// - Keyboard data pin level appears on port 1 bit 0.
// - Mouse clock pin pulled low while port 2 bit 3 is one.
// - Mouse clock pin level feeds test input one.
// - Mouse data pin pulled low while port 2 bit 2 is one.
// - Mouse data pin level appears on port 1 bit 1.
// - Gate A20 open-drain follows port 2 bit 1, readable back.
// - Keyboard reset open-drain follows port 2 bit 0, readable back.
// - Activity on keyboard or mouse pins raises a wake event.
// - Three open-drain lines follow port 1 bits 2, 6, 7, readable back.
//
// Implementation choices: the placing of the registers and the APB register port.
`timescale 1ns/1ns
`include "kmpa_params.svh"

module kmpa_adapter
(
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [`KMPA_ADDR_W-1:0] paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire logic [7:0]              port2_out,
  input  wire logic                    port2_wr,
  input  wire logic [7:0]              port1_out,
  input  wire logic                    port1_wr,
  output logic      [7:0]              port1_in,
  output logic      [1:0]              port2_in,
  output logic                         test_input_zero,
  output logic                         test_input_one,
  input  wire logic                    kbd_clock_pin_i,
  output logic                         kbd_clock_pin_o,
  output logic                         kbd_clock_pin_oe,
  input  wire logic                    kbd_data_pin_i,
  output logic                         kbd_data_pin_o,
  output logic                         kbd_data_pin_oe,
  input  wire logic                    mouse_clock_pin_i,
  output logic                         mouse_clock_pin_o,
  output logic                         mouse_clock_pin_oe,
  input  wire logic                    mouse_data_pin_i,
  output logic                         mouse_data_pin_o,
  output logic                         mouse_data_pin_oe,
  input  wire logic                    gate_a20_line_i,
  output logic                         gate_a20_line_o,
  output logic                         gate_a20_line_oe,
  input  wire logic                    kbd_reset_line_i,
  output logic                         kbd_reset_line_o,
  output logic                         kbd_reset_line_oe,
  input  wire logic                    gp2_line_i,
  output logic                         gp2_line_o,
  output logic                         gp2_line_oe,
  input  wire logic                    gp6_line_i,
  output logic                         gp6_line_o,
  output logic                         gp6_line_oe,
  input  wire logic                    gp7_line_i,
  output logic                         gp7_line_o,
  output logic                         gp7_line_oe,
  output logic                         wake_event,
  output logic                         irq
);

  kmpa_pkg::kmpa_pins_t raw_pins;
  kmpa_pkg::kmpa_pins_t lvl;
  kmpa_pkg::kmpa_pins_t oe_q;
  kmpa_pkg::kmpa_pins_t next_oe;
  kmpa_pkg::kmpa_wake_t prev_wk;
  kmpa_pkg::kmpa_wake_t fall_wk;
  kmpa_pkg::kmpa_wake_t wake_stat;
  kmpa_pkg::kmpa_wake_t wake_mask;
  kmpa_pkg::kmpa_wake_t next_stat;
  kmpa_pkg::kmpa_wake_t w1c;
  kmpa_pkg::kmpa_ctrl_t ctrl;
  logic                 od_level;
  logic                 force_rel;
  logic                 wake_en;
  logic                 setup_ph;
  logic                 wr_acc;
  logic                 hit_lvl;
  logic                 hit_stat;
  logic                 hit_mask;
  logic                 hit_ctrl;
  logic                 hit_any;
  logic [31:0]          rd_mux;

  // ==========================================================
  // Helper functions
  function automatic logic kmpa_hit(input logic [`KMPA_ADDR_W-1:0] a,
                                    input logic [`KMPA_ADDR_W-1:0] off);
    kmpa_hit = (a == off);
  endfunction

  function automatic kmpa_pkg::kmpa_wake_t kmpa_fall(input kmpa_pkg::kmpa_wake_t p,
                                                    input kmpa_pkg::kmpa_wake_t c);
    kmpa_fall = p & ~c;
  endfunction

  // ==========================================================
  // Pin sensing through the synchroniser
  assign raw_pins = {gp7_line_i, gp6_line_i, gp2_line_i, kbd_reset_line_i,
                     gate_a20_line_i, mouse_data_pin_i, mouse_clock_pin_i,
                     kbd_data_pin_i, kbd_clock_pin_i};

  kmpa_sync u_sync
  (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (raw_pins),
    .dout    (lvl)
  );

  // Synchronised levels handed to the core ports
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      test_input_zero <= 1'h1;
      test_input_one  <= 1'h1;
      port1_in        <= 8'hFF;
      port2_in        <= 2'h3;
    end
    else
    begin
      test_input_zero <= lvl[`KMPA_PIN_KCLK];
      test_input_one  <= lvl[`KMPA_PIN_MCLK];
      port1_in[`KMPA_P1_KDAT] <= lvl[`KMPA_PIN_KDAT];
      port1_in[`KMPA_P1_MOUSE_DATA_PIN] <= lvl[`KMPA_PIN_MOUSE_DATA_PIN];
      port1_in[`KMPA_P1_GP2]  <= lvl[`KMPA_PIN_GP2];
      port1_in[`KMPA_P1_GP6]  <= lvl[`KMPA_PIN_GP6];
      port1_in[`KMPA_P1_GP7]  <= lvl[`KMPA_PIN_GP7];
      port2_in[`KMPA_P2_GATE_A20_LINE] <= lvl[`KMPA_PIN_GATE_A20_LINE];
      port2_in[`KMPA_P2_KRST] <= lvl[`KMPA_PIN_KRST];
    end
  end

  // ==========================================================
  // Open-drain drive enables, one per pin
  assign force_rel = ctrl[`KMPA_CTRL_FORCE];
  assign next_oe[`KMPA_PIN_KCLK] = port2_wr ? port2_out[`KMPA_P2_KCLK]
                                            : oe_q[`KMPA_PIN_KCLK];
  assign next_oe[`KMPA_PIN_KDAT] = port2_wr ? port2_out[`KMPA_P2_KDAT]
                                            : oe_q[`KMPA_PIN_KDAT];
  assign next_oe[`KMPA_PIN_MCLK] = port2_wr ? port2_out[`KMPA_P2_MCLK]
                                            : oe_q[`KMPA_PIN_MCLK];
  assign next_oe[`KMPA_PIN_MOUSE_DATA_PIN] = port2_wr ? port2_out[`KMPA_P2_MOUSE_DATA_PIN]
                                            : oe_q[`KMPA_PIN_MOUSE_DATA_PIN];
  assign next_oe[`KMPA_PIN_GATE_A20_LINE] = port2_wr ? ~port2_out[`KMPA_P2_GATE_A20_LINE]
                                            : oe_q[`KMPA_PIN_GATE_A20_LINE];
  assign next_oe[`KMPA_PIN_KRST] = port2_wr ? ~port2_out[`KMPA_P2_KRST]
                                            : oe_q[`KMPA_PIN_KRST];
  assign next_oe[`KMPA_PIN_GP2]  = port1_wr ? ~port1_out[`KMPA_P1_GP2]
                                            : oe_q[`KMPA_PIN_GP2];
  assign next_oe[`KMPA_PIN_GP6]  = port1_wr ? ~port1_out[`KMPA_P1_GP6]
                                            : oe_q[`KMPA_PIN_GP6];
  assign next_oe[`KMPA_PIN_GP7]  = port1_wr ? ~port1_out[`KMPA_P1_GP7]
                                            : oe_q[`KMPA_PIN_GP7];

  // Enables released at reset, and while software forces release
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      oe_q     <= 9'h000;
      od_level <= 1'h0;
    end
    else
    begin
      oe_q     <= force_rel ? 9'h000 : next_oe;
      od_level <= 1'h0;
    end
  end

  // Pin outputs straight from the enable flops
  assign kbd_clock_pin_oe   = oe_q[`KMPA_PIN_KCLK];
  assign kbd_data_pin_oe    = oe_q[`KMPA_PIN_KDAT];
  assign mouse_clock_pin_oe = oe_q[`KMPA_PIN_MCLK];
  assign mouse_data_pin_oe  = oe_q[`KMPA_PIN_MOUSE_DATA_PIN];
  assign gate_a20_line_oe   = oe_q[`KMPA_PIN_GATE_A20_LINE];
  assign kbd_reset_line_oe  = oe_q[`KMPA_PIN_KRST];
  assign gp2_line_oe        = oe_q[`KMPA_PIN_GP2];
  assign gp6_line_oe        = oe_q[`KMPA_PIN_GP6];
  assign gp7_line_oe        = oe_q[`KMPA_PIN_GP7];
  assign kbd_clock_pin_o    = od_level;
  assign kbd_data_pin_o     = od_level;
  assign mouse_clock_pin_o  = od_level;
  assign mouse_data_pin_o   = od_level;
  assign gate_a20_line_o    = od_level;
  assign kbd_reset_line_o   = od_level;
  assign gp2_line_o         = od_level;
  assign gp6_line_o         = od_level;
  assign gp7_line_o         = od_level;

  // ==========================================================
  // Wake detection on falling edges of the four link pins
  assign wake_en   = ctrl[`KMPA_CTRL_WAKE_EN];
  assign fall_wk   = wake_en ? kmpa_fall(prev_wk, lvl[`KMPA_NWAKE-1:0])
                             : 4'h0;
  assign w1c       = (wr_acc && hit_stat) ? pwdata[`KMPA_NWAKE-1:0] : 4'h0;
  assign next_stat = (wake_stat & ~w1c) | fall_wk;   // Set beats clear

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prev_wk    <= 4'hF;
      wake_stat  <= 4'h0;
      wake_event <= 1'h0;
      irq        <= 1'h0;
    end
    else
    begin
      prev_wk    <= lvl[`KMPA_NWAKE-1:0];
      wake_stat  <= next_stat;
      wake_event <= |fall_wk;
      irq        <= |(next_stat & wake_mask);
    end
  end

  // ==========================================================
  // APB decode, zero-wait access phase
  assign setup_ph = psel && !penable;
  assign wr_acc   = psel && penable && pready && pwrite;
  assign hit_lvl  = kmpa_hit(paddr, `KMPA_OFF_LEVELS);
  assign hit_stat = kmpa_hit(paddr, `KMPA_OFF_WAKE_STAT);
  assign hit_mask = kmpa_hit(paddr, `KMPA_OFF_WAKE_MASK);
  assign hit_ctrl = kmpa_hit(paddr, `KMPA_OFF_CTRL);
  assign hit_any  = hit_lvl || hit_stat || hit_mask || hit_ctrl;
  assign rd_mux   = hit_lvl  ? {7'h00, oe_q, 7'h00, lvl} :
                    hit_stat ? {28'h0000000, wake_stat} :
                    hit_mask ? {28'h0000000, wake_mask} :
                    hit_ctrl ? {30'h00000000, ctrl} : 32'h00000000;

  // Answer prepared in setup, presented in access
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'h0;
      pslverr <= 1'h0;
      prdata  <= 32'h00000000;
    end
    else
    begin
      pready  <= setup_ph;
      pslverr <= setup_ph && !hit_any;
      prdata  <= (setup_ph && !pwrite) ? rd_mux : 32'h00000000;
    end
  end

  // Writable registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wake_mask <= 4'h0;
      ctrl      <= `KMPA_CTRL_RST;
    end
    else
    begin
      if (wr_acc && hit_mask)
        wake_mask <= pwdata[`KMPA_NWAKE-1:0];
      if (wr_acc && hit_ctrl)
        ctrl <= pwdata[`KMPA_CTRL_W-1:0];
    end
  end

  // ==========================================================
  // Assertion helpers: settle counter and first-write flag
  logic [2:0] alive_cnt;
  logic       alive;
  logic       wr_seen;
  assign alive = (alive_cnt == `KMPA_ALIVE_CYC);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      alive_cnt <= 3'h0;
      wr_seen   <= 1'h0;
    end
    else
    begin
      alive_cnt <= alive ? alive_cnt : alive_cnt + 3'h1;
      wr_seen   <= wr_seen || port1_wr || port2_wr;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ==========================================================
  // Assertions
  property p_kclk_drive;
    (port2_wr && !force_rel) |=> kbd_clock_pin_oe == $past(port2_out[`KMPA_P2_KCLK]);
  endproperty
  a_kclk_drive: assert property (p_kclk_drive) else $error("kbd clock drive wrong");

  property p_t0_level;
    alive |-> test_input_zero == $past(kbd_clock_pin_i, 3);
  endproperty
  a_t0_level: assert property (p_t0_level) else $error("test input zero wrong");

  property p_kdat_drive;
    (port2_wr && !force_rel && port2_out[`KMPA_P2_KDAT]) |=> kbd_data_pin_oe;
  endproperty
  a_kdat_drive: assert property (p_kdat_drive) else $error("kbd data not pulled");

  property p_kdat_level;
    alive |-> port1_in[`KMPA_P1_KDAT] == $past(kbd_data_pin_i, 3);
  endproperty
  a_kdat_level: assert property (p_kdat_level) else $error("port1 bit0 wrong");

  property p_mclk_drive;
    (port2_wr && !force_rel && !port2_out[`KMPA_P2_MCLK]) |=> !mouse_clock_pin_oe;
  endproperty
  a_mclk_drive: assert property (p_mclk_drive) else $error("mouse clock held");

  property p_t1_level;
    alive |-> test_input_one == $past(mouse_clock_pin_i, 3);
  endproperty
  a_t1_level: assert property (p_t1_level) else $error("test input one wrong");

  property p_mouse_data_pin_drive;
    (port2_wr && !force_rel) |=> mouse_data_pin_oe == $past(port2_out[`KMPA_P2_MOUSE_DATA_PIN]);
  endproperty
  a_mouse_data_pin_drive: assert property (p_mouse_data_pin_drive) else $error("mouse data drive wrong");

  property p_mouse_data_pin_level;
    alive |-> port1_in[`KMPA_P1_MOUSE_DATA_PIN] == $past(mouse_data_pin_i, 3);
  endproperty
  a_mouse_data_pin_level: assert property (p_mouse_data_pin_level) else $error("port1 bit1 wrong");

  property p_gate_a20_line_drive;
    (port2_wr && !force_rel && !port2_out[`KMPA_P2_GATE_A20_LINE]) |=> gate_a20_line_oe;
  endproperty
  a_gate_a20_line_drive: assert property (p_gate_a20_line_drive) else $error("gate a20 not low");

  property p_krst_drive;
    (port2_wr && !force_rel) |=> kbd_reset_line_oe != $past(port2_out[`KMPA_P2_KRST]);
  endproperty
  a_krst_drive: assert property (p_krst_drive) else $error("kbd reset drive wrong");

  property p_wake_set;
    (wake_en && prev_wk[`KMPA_PIN_KDAT] && !lvl[`KMPA_PIN_KDAT])
      |=> wake_stat[`KMPA_PIN_KDAT] && wake_event;
  endproperty
  a_wake_set: assert property (p_wake_set) else $error("wake event lost");

  property p_gp_drive;
    (port1_wr && !force_rel) |=> gp7_line_oe == !$past(port1_out[`KMPA_P1_GP7]);
  endproperty
  a_gp_drive: assert property (p_gp_drive) else $error("gp7 drive wrong");

  property p_sync_lag;
    (alive && $changed(test_input_one))
      |-> $past(mouse_clock_pin_i, 3) != $past(mouse_clock_pin_i, 4);
  endproperty
  a_sync_lag: assert property (p_sync_lag) else $error("sync lag wrong");

  property p_release;
    !wr_seen |-> oe_q == 9'h000;
  endproperty
  a_release: assert property (p_release) else $error("drive before write");

  // Covers
  c_irq:   cover property (!irq ##1 irq);
  c_kclk:  cover property (kbd_clock_pin_oe ##1 !kbd_clock_pin_oe);
  c_force: cover property (force_rel && port2_wr);
  c_err:   cover property (pslverr && pready);

endmodule

// ### src/kmpa_params.svh
// Constants of the keyboard and mouse pin adapter.
// Assumes inclusion by bare name from the package and the adapter modules.
`ifndef KMPA_PARAMS_SVH
`define KMPA_PARAMS_SVH

// ==========================================================
// Register offsets on the APB slave (byte addresses)
`define KMPA_ADDR_W        12
`define KMPA_OFF_LEVELS    12'h000
`define KMPA_OFF_WAKE_STAT 12'h004
`define KMPA_OFF_WAKE_MASK 12'h008
`define KMPA_OFF_CTRL      12'h00C

// ==========================================================
// Control register fields and reset value
`define KMPA_CTRL_W        2
`define KMPA_CTRL_WAKE_EN  0
`define KMPA_CTRL_FORCE    1
`define KMPA_CTRL_RST      2'h1

// ==========================================================
// Pin index inside the sensed and driven vectors
`define KMPA_NPINS         9
`define KMPA_PIN_KCLK      0
`define KMPA_PIN_KDAT      1
`define KMPA_PIN_MCLK      2
`define KMPA_PIN_MOUSE_DATA_PIN      3
`define KMPA_PIN_GATE_A20_LINE      4
`define KMPA_PIN_KRST      5
`define KMPA_PIN_GP2       6
`define KMPA_PIN_GP6       7
`define KMPA_PIN_GP7       8
`define KMPA_NWAKE         4
`define KMPA_PINS_IDLE     9'h1FF

// ==========================================================
// Controller core port bit positions
`define KMPA_P2_KCLK       6
`define KMPA_P2_KDAT       7
`define KMPA_P2_MCLK       3
`define KMPA_P2_MOUSE_DATA_PIN       2
`define KMPA_P2_GATE_A20_LINE       1
`define KMPA_P2_KRST       0
`define KMPA_P1_KDAT       0
`define KMPA_P1_MOUSE_DATA_PIN       1
`define KMPA_P1_GP2        2
`define KMPA_P1_GP6        6
`define KMPA_P1_GP7        7
`define KMPA_ALIVE_CYC     3'h4

`endif

// ### src/kmpa_pkg.sv
// Types shared by the keyboard and mouse pin adapter.
// Assumes the constants header is on the include path.
`include "kmpa_params.svh"

package kmpa_pkg;

  // ==========================================================
  // Vector types
  typedef logic [`KMPA_NPINS-1:0]  kmpa_pins_t;
  typedef logic [`KMPA_NWAKE-1:0]  kmpa_wake_t;
  typedef logic [`KMPA_CTRL_W-1:0] kmpa_ctrl_t;
  typedef logic [7:0]              kmpa_port_t;

endpackage

// ### src/kmpa_sync.sv
// Two-flop synchroniser for a vector of asynchronous pin levels.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ns
`include "kmpa_params.svh"

module kmpa_sync
#(
  parameter int                 WIDTH = `KMPA_NPINS,
  parameter logic [WIDTH-1:0]   IDLE  = `KMPA_PINS_IDLE
)
(
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta;

  // ==========================================================
  // First stage feeds only the second stage
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta <= IDLE;
      dout <= IDLE;
    end
    else
    begin
      meta <= din;
      dout <= meta;
    end
  end

endmodule

// ### verification/kmpa_adapter_test.sv
// Self-checking bench of the keyboard and mouse pin adapter.
// Assumes the design sources and the link device model compile first.
`timescale 1ns/1ns
`include "kmpa_params.svh"

module kmpa_adapter_test;
  // ==========================================================
  // Bench signals
  logic        pclk = 1'h0;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [7:0]  p2_out;
  logic        p2_wr;
  logic [7:0]  p1_out;
  logic        p1_wr;
  logic [7:0]  port1_in;
  logic [1:0]  port2_in;
  logic        tin0;
  logic        tin1;
  logic        wake_event;
  logic        irq;
  logic        kb_ck;
  logic        kb_dt;
  logic        ms_ck;
  logic        ms_dt;
  wire  [8:0]  oe;
  wire  [8:0]  pin;
  int          err_total = 0;
  int          checked = 0;
  int          wake_cnt = 0;
  int          cyc = 0;
  int          n0;
  logic [7:0]  last2 = 8'h03;
  logic [7:0]  p2_pat [8] = '{8'h40, 8'h80, 8'h08, 8'h04, 8'h00, 8'hCF, 8'h01, 8'h03};
  logic [7:0]  p1_pat [5] = '{8'hFB, 8'hBF, 8'h7F, 8'h00, 8'hFF};

  // Open-drain wires with pull-ups
  assign pin = ~(oe | {5'h00, ms_dt, ms_ck, kb_dt, kb_ck});

  always #5 pclk = ~pclk;

  kmpa_adapter i_dut
  (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .port2_out(p2_out), .port2_wr(p2_wr), .port1_out(p1_out), .port1_wr(p1_wr),
    .port1_in(port1_in), .port2_in(port2_in), .test_input_zero(tin0),
    .test_input_one(tin1), .wake_event(wake_event), .irq(irq),
    .kbd_clock_pin_i(pin[0]), .kbd_clock_pin_o(), .kbd_clock_pin_oe(oe[0]),
    .kbd_data_pin_i(pin[1]), .kbd_data_pin_o(), .kbd_data_pin_oe(oe[1]),
    .mouse_clock_pin_i(pin[2]), .mouse_clock_pin_o(), .mouse_clock_pin_oe(oe[2]),
    .mouse_data_pin_i(pin[3]), .mouse_data_pin_o(), .mouse_data_pin_oe(oe[3]),
    .gate_a20_line_i(pin[4]), .gate_a20_line_o(), .gate_a20_line_oe(oe[4]),
    .kbd_reset_line_i(pin[5]), .kbd_reset_line_o(), .kbd_reset_line_oe(oe[5]),
    .gp2_line_i(pin[6]), .gp2_line_o(), .gp2_line_oe(oe[6]),
    .gp6_line_i(pin[7]), .gp6_line_o(), .gp6_line_oe(oe[7]),
    .gp7_line_i(pin[8]), .gp7_line_o(), .gp7_line_oe(oe[8])
  );

  kmpa_link_dev i_kbd (.clk_line(pin[0]), .clk_pull(kb_ck), .dat_pull(kb_dt));
  kmpa_link_dev i_mouse (.clk_line(pin[2]), .clk_pull(ms_ck), .dat_pull(ms_dt));

  // ==========================================================
  // Shared tasks
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer, held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'h1;
    // Wait for the answer; only the hang guard ends a stuck wait
    do
      @(posedge pclk);
    while (pready !== 1'h1);
    r = prdata;
    e = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'h1, a, d, r, e);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic        e;
    apb(1'h0, a, 32'h0, r, e);
    chk(r, x);
    chk(32'(e), 32'(xe));
  endtask

  // Core port write with a one-cycle strobe
  task automatic port_wr(input logic two, input logic [7:0] v);
    @(posedge pclk);
    p2_out <= v;
    p1_out <= v;
    p2_wr  <= two;
    p1_wr  <= ~two;
    @(posedge pclk);
    p2_wr  <= 1'h0;
    p1_wr  <= 1'h0;
    #1;
  endtask

  // Expected core inputs for a port 2 value: t0, t1, readback, p1[1:0]
  function automatic logic [5:0] exp_in(input logic [7:0] x);
    return {~x[6], ~x[3], x[1], x[0], ~x[2], ~x[7]};
  endfunction

  task automatic chk_p2(input logic [7:0] v);
    port_wr(1'h1, v);
    chk(32'(oe[5:0]), 32'({~v[0], ~v[1], v[2], v[3], v[7], v[6]}));
    repeat (2) @(posedge pclk);
    #1;
    chk(32'({tin0, tin1, port2_in, port1_in[1:0]}), 32'(exp_in(last2)));
    @(posedge pclk);
    #1;
    chk(32'({tin0, tin1, port2_in, port1_in[1:0]}), 32'(exp_in(v)));
    last2 = v;
  endtask

  task automatic chk_p1(input logic [7:0] v);
    port_wr(1'h0, v);
    chk(32'(oe[8:6]), 32'({~v[7], ~v[6], ~v[2]}));
    repeat (3) @(posedge pclk);
    #1;
    chk(32'(port1_in[7:2]), 32'({v[7], v[6], 3'h7, v[2]}));
  endtask

  // ==========================================================
  // Hang guard and wake pulse counter
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (wake_event === 1'h1)
      wake_cnt <= wake_cnt + 1;
    if (cyc == 20000)
    begin
      err_total = err_total + 1;
      give_verdict();
    end
  end

  // ==========================================================
  // Main sequence
  initial
  begin
    presetn = 1'h0;
    psel    = 1'h0;
    penable = 1'h0;
    pwrite  = 1'h0;
    paddr   = 12'h000;
    pwdata  = 32'h0;
    p2_out  = 8'h00;
    p2_wr   = 1'h0;
    p1_out  = 8'h00;
    p1_wr   = 1'h0;
    repeat (12) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    #1;
    chk(32'(oe), 32'h0);
    chk(32'({port1_in, port2_in, tin0, tin1, irq}), 32'h1FFE);
    rd_chk(`KMPA_OFF_LEVELS, 32'h0000_01FF, 1'h0);
    rd_chk(`KMPA_OFF_WAKE_MASK, 32'h0, 1'h0);
    rd_chk(`KMPA_OFF_CTRL, 32'h1, 1'h0);
    rd_chk(12'h010, 32'h0, 1'h1);
    $display("Test reset and registers done");

    foreach (p2_pat[i])
      chk_p2(p2_pat[i]);
    foreach (p1_pat[i])
      chk_p1(p1_pat[i]);
    port_wr(1'h1, 8'h40);
    port_wr(1'h0, 8'hFB);
    repeat (4) @(posedge pclk);
    rd_chk(`KMPA_OFF_LEVELS, 32'h0071_018E, 1'h0);
    wr(`KMPA_OFF_CTRL, 32'h3);
    port_wr(1'h1, 8'hCC);
    repeat (4) @(posedge pclk);
    rd_chk(`KMPA_OFF_LEVELS, 32'h0000_01FF, 1'h0);
    wr(`KMPA_OFF_CTRL, 32'h1);
    port_wr(1'h1, 8'h03);
    port_wr(1'h0, 8'hFF);
    $display("Test port pins done");

    // Own pulls above left falling edges on all four link pins
    repeat (4) @(posedge pclk);
    rd_chk(`KMPA_OFF_WAKE_STAT, 32'hF, 1'h0);
    chk(32'(irq), 32'h0);
    wr(`KMPA_OFF_WAKE_STAT, 32'hF);
    rd_chk(`KMPA_OFF_WAKE_STAT, 32'h0, 1'h0);
    wr(`KMPA_OFF_WAKE_MASK, 32'hF);
    rd_chk(`KMPA_OFF_WAKE_MASK, 32'hF, 1'h0);
    n0 = wake_cnt;
    i_kbd.send_frame(8'hA5, 3);
    repeat (10) @(posedge pclk);
    #1;
    chk(32'(wake_cnt != n0), 32'h1);
    chk(32'(irq), 32'h1);
    rd_chk(`KMPA_OFF_WAKE_STAT, 32'h3, 1'h0);
    wr(`KMPA_OFF_WAKE_STAT, 32'h3);
    wr(`KMPA_OFF_WAKE_MASK, 32'h3);
    repeat (2) @(posedge pclk);
    #1;
    chk(32'(irq), 32'h0);
    i_mouse.send_frame(8'h3C, 170);
    repeat (10) @(posedge pclk);
    #1;
    rd_chk(`KMPA_OFF_WAKE_STAT, 32'hC, 1'h0);
    chk(32'(irq), 32'h0);
    wr(`KMPA_OFF_WAKE_STAT, 32'hC);
    wr(`KMPA_OFF_CTRL, 32'h0);
    n0 = wake_cnt;
    i_kbd.send_frame(8'h00, 7);
    repeat (10) @(posedge pclk);
    #1;
    chk(32'(wake_cnt == n0), 32'h1);
    rd_chk(`KMPA_OFF_WAKE_STAT, 32'h0, 1'h0);
    wr(`KMPA_OFF_CTRL, 32'h1);
    $display("Test wake events done");
    give_verdict();
  end
endmodule

// ### verification/kmpa_link_dev.sv
// Behavioural keyboard or mouse on the two-wire open-drain link.
// Assumes an external pull-up; a pull output of 1 drives the line low.
`timescale 1ns/1ns

module kmpa_link_dev
(
  input  wire logic clk_line,
  output logic      clk_pull,
  output logic      dat_pull
);
  // ==========================================================
  // Link timing: 80 ns clock, still between frames
  localparam int HALF = 40;

  initial
  begin
    clk_pull = 1'h0;
    dat_pull = 1'h0;
  end

  // Start, eight data bits LSB first, odd parity, stop
  task automatic send_frame(input logic [7:0] b, input int gap);
    logic [10:0] f;
    f = {1'h1, ~^b, b, 1'h0};
    wait (clk_line === 1'h1);   // Host inhibit holds the frame off
    #(gap);                     // Phase unrelated to the bus clock
    for (int i = 0; i < 11; i++)
    begin
      dat_pull = ~f[i];
      #(HALF / 2);
      clk_pull = 1'h1;
      #(HALF);
      clk_pull = 1'h0;
      #(HALF / 2);
    end
    dat_pull = 1'h0;            // Released: pull-up takes line high
  endtask
endmodule
